// File: design/trim_alert_select_registers.sv
// Trim and alert-select register bank with fault alert combiner.
// Assumes the SMBus engine and the EEPROM loader run on clock_i; flag inputs are asynchronous.
`timescale 1ns/10ps
module trim_alert_select_registers
   import trim_alert_pkg::*;
#(
   // Arbitrary neutral identity values
   parameter logic [7:0] MAKER_ID = 8'h5A,
   parameter logic [3:0] REV_MAJOR = 4'h2,
   parameter logic [3:0] REV_MINOR = 4'h3
) (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire reg_req_type reg_req_i,
   output logic [7:0] reg_rdata_o,
   output logic reg_rd_ack_o,
   input wire ee_load_type ee_load_i,
   input wire fault_flags_type fault_flags_i,
   input wire monitor_flags_type monitor_flags_i,
   output logic [7:0] false_undervoltage_clamp_trim_o,
   output logic [7:0] load_voltage_trim_o,
   output logic [7:0] alert_mask_faults_o,
   output logic [7:0] alert_mask_monitors_o,
   output logic fault_alert_output_o
);
   typedef struct packed {
      logic [7:0] uv_trim;
      logic [7:0] lv_trim;
      logic [7:0] alert_mask_faults;
      logic [7:0] alert_mask_monitors;
      logic [7:0] rdata;
      logic rd_ack;
      logic [7:0] fault_meta;
      logic [7:0] fault_sync;
      logic [7:0] mon_meta;
      logic [7:0] mon_sync;
   } state_type;

   state_type cur_ff;
   state_type nxt_state;
   logic [7:0] fault_raw;
   logic [7:0] mon_raw;
   logic [7:0] fault_sense;
   logic [7:0] mon_sense;
   logic [7:0] silicon_rev;

   assign silicon_rev = {REV_MAJOR, REV_MINOR}; // see [R10]

   // Micro request and unused slots carry no pin, held low
   assign fault_raw = fault_flags_i;
   assign mon_raw = {monitor_flags_i.supply_good, monitor_flags_i.mon1_flag,
                     monitor_flags_i.mon2_flag, monitor_flags_i.mon3_flag,
                     monitor_flags_i.mon4_flag, 1'b0,
                     monitor_flags_i.supervisor_input_five_flag, 1'b0};

   // Inversion after the second stage keeps the first stage private
   assign fault_sense = cur_ff.fault_sync ^ FAULT_INVERT; // see [R5]
   assign mon_sense = (cur_ff.mon_sync ^ MON_INVERT) & MON_GATE; // see [R7]

   always_comb begin
      nxt_state = cur_ff;
      nxt_state.rd_ack = 1'b0;
      nxt_state.fault_meta = fault_raw;
      nxt_state.fault_sync = cur_ff.fault_meta;
      nxt_state.mon_meta = mon_raw;
      nxt_state.mon_sync = cur_ff.mon_meta;
      // Host write first; a loader byte in the same cycle overrides it
      if (reg_req_i.wr) begin // see [R11]
         case (reg_req_i.addr)
            ADDR_FALSE_UNDERVOLTAGE_CLAMP_TRIM: nxt_state.uv_trim = reg_req_i.wdata; // see [R1]
            ADDR_LOAD_VOLT_TRIM: nxt_state.lv_trim = reg_req_i.wdata; // see [R3]
            ADDR_ALERT_SEL_FAULTS: nxt_state.alert_mask_faults = reg_req_i.wdata;
            ADDR_ALERT_SEL_MONITORS: nxt_state.alert_mask_monitors = reg_req_i.wdata; // see [R8]
            // Identity registers and unmapped offsets ignore writes
            default: nxt_state.rdata = cur_ff.rdata; // see [R9]
         endcase
      end
      if (ee_load_i.load) begin
         case (ee_load_i.addr)
            EE_FALSE_UNDERVOLTAGE_CLAMP_TRIM: nxt_state.uv_trim = ee_load_i.data; // see [R2]
            EE_LOAD_VOLT_TRIM: nxt_state.lv_trim = ee_load_i.data; // see [R3]
            EE_ALERT_SEL_FAULTS: nxt_state.alert_mask_faults = ee_load_i.data; // see [R6]
            EE_ALERT_SEL_MONITORS: nxt_state.alert_mask_monitors = ee_load_i.data; // see [R7]
            default: nxt_state.rdata = nxt_state.rdata;
         endcase
      end
      if (reg_req_i.rd) begin // see [R11]
         nxt_state.rd_ack = 1'b1;
         case (reg_req_i.addr)
            ADDR_FALSE_UNDERVOLTAGE_CLAMP_TRIM: nxt_state.rdata = cur_ff.uv_trim;
            ADDR_LOAD_VOLT_TRIM: nxt_state.rdata = cur_ff.lv_trim;
            ADDR_ALERT_SEL_FAULTS: nxt_state.rdata = cur_ff.alert_mask_faults;
            ADDR_ALERT_SEL_MONITORS: nxt_state.rdata = cur_ff.alert_mask_monitors;
            ADDR_MAKER_ID: nxt_state.rdata = MAKER_ID; // see [R9]
            ADDR_SILICON_REV: nxt_state.rdata = silicon_rev; // see [R10]
            default: nxt_state.rdata = READ_UNMAPPED;
         endcase
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         cur_ff <= '0;
      end else if (ce_i) begin
         cur_ff <= nxt_state;
      end
   end

   // Combinational so a cleared flag releases the pin once it leaves the two sync stages, with no further register
   assign fault_alert_output_o = (|(fault_sense & cur_ff.alert_mask_faults))
                                 | (|(mon_sense & cur_ff.alert_mask_monitors))
                                 | cur_ff.alert_mask_monitors[MB_MICRO]; // see [R4] [R12]

   // Trim codes leave as plain binary; the analog side scales per step
   assign false_undervoltage_clamp_trim_o = cur_ff.uv_trim; // see [R1]
   assign load_voltage_trim_o = cur_ff.lv_trim;
   assign alert_mask_faults_o = cur_ff.alert_mask_faults;
   assign alert_mask_monitors_o = cur_ff.alert_mask_monitors;
   assign reg_rdata_o = cur_ff.rdata;
   assign reg_rd_ack_o = cur_ff.rd_ack;

   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (rst_i);

   uv_host_write_a: assert property ( // see [R1]
      (ce_i && reg_req_i.wr && reg_req_i.addr == ADDR_FALSE_UNDERVOLTAGE_CLAMP_TRIM && !ee_load_i.load)
      |=> false_undervoltage_clamp_trim_o == $past(reg_req_i.wdata))
      else $error("clamp trim write not stored");

   uv_ee_load_a: assert property ( // see [R2]
      (ce_i && ee_load_i.load && ee_load_i.addr == EE_FALSE_UNDERVOLTAGE_CLAMP_TRIM)
      |=> false_undervoltage_clamp_trim_o == $past(ee_load_i.data))
      else $error("clamp trim preload missed");

   lv_ee_load_a: assert property ( // see [R3]
      (ce_i && ee_load_i.load && ee_load_i.addr == EE_LOAD_VOLT_TRIM
       && !(reg_req_i.wr && reg_req_i.addr == ADDR_FALSE_UNDERVOLTAGE_CLAMP_TRIM))
      |=> load_voltage_trim_o == $past(ee_load_i.data) && $stable(false_undervoltage_clamp_trim_o))
      else $error("load trim preload wrong");

   alert_or_a: assert property ( // see [R4]
      (|(fault_sense & alert_mask_faults_o)) |-> fault_alert_output_o)
      else $error("enabled fault did not raise alert");

   ov_bit_a: assert property ( // see [R5]
      (ce_i && $past(ce_i) && fault_flags_i.ov_fault && $past(fault_flags_i.ov_fault)
       && alert_mask_faults_o[FB_OV]) |=> ##1 ($past(alert_mask_faults_o[FB_OV])
       && alert_mask_faults_o[FB_OV]) |-> fault_alert_output_o)
      else $error("overvoltage bit does not gate alert");

   fmask_ee_load_a: assert property ( // see [R6]
      (ce_i && ee_load_i.load && ee_load_i.addr == EE_ALERT_SEL_FAULTS)
      |=> alert_mask_faults_o == $past(ee_load_i.data))
      else $error("fault mask preload missed");

   mmask_ee_load_a: assert property ( // see [R7]
      (ce_i && ee_load_i.load && ee_load_i.addr == EE_ALERT_SEL_MONITORS)
      |=> alert_mask_monitors_o == $past(ee_load_i.data))
      else $error("monitor mask preload missed");

   micro_req_a: assert property ( // see [R8]
      (ce_i && reg_req_i.wr && reg_req_i.addr == ADDR_ALERT_SEL_MONITORS
       && reg_req_i.wdata[MB_MICRO] && !ee_load_i.load) |=> fault_alert_output_o)
      else $error("micro request did not raise alert");

   maker_ro_a: assert property ( // see [R9]
      (ce_i && reg_req_i.rd && reg_req_i.addr == ADDR_MAKER_ID)
      |=> reg_rd_ack_o && reg_rdata_o == MAKER_ID)
      else $error("maker id read wrong");

   revision_read_a: assert property ( // see [R10]
      (ce_i && reg_req_i.rd && reg_req_i.addr == ADDR_SILICON_REV)
      |=> reg_rdata_o[7:4] == REV_MAJOR && reg_rdata_o[3:0] == REV_MINOR)
      else $error("revision read wrong");

   read_ack_a: assert property ( // see [R11]
      (ce_i && reg_req_i.rd) |=> reg_rd_ack_o
      ##1 (!reg_rd_ack_o || $past(reg_req_i.rd) || !$past(ce_i)))
      else $error("read answer not one cycle");

   alert_release_a: assert property ( // see [R12]
      ((fault_sense & alert_mask_faults_o) == 8'h00
       && (mon_sense & alert_mask_monitors_o) == 8'h00
       && !alert_mask_monitors_o[MB_MICRO]) |-> !fault_alert_output_o)
      else $error("alert held with nothing enabled");

   lv_host_write_a: assert property ( // see [R3]
      (ce_i && reg_req_i.wr && reg_req_i.addr == ADDR_LOAD_VOLT_TRIM && !ee_load_i.load)
      |=> load_voltage_trim_o == $past(reg_req_i.wdata))
      else $error("load trim write not stored");

   fmask_host_write_a: assert property ( // see [R5]
      (ce_i && reg_req_i.wr && reg_req_i.addr == ADDR_ALERT_SEL_FAULTS && !ee_load_i.load)
      |=> alert_mask_faults_o == $past(reg_req_i.wdata))
      else $error("fault mask write not stored");

   mmask_host_write_a: assert property ( // see [R7]
      (ce_i && reg_req_i.wr && reg_req_i.addr == ADDR_ALERT_SEL_MONITORS && !ee_load_i.load)
      |=> alert_mask_monitors_o == $past(reg_req_i.wdata))
      else $error("monitor mask write not stored");

   fmask_write_only_a: assert property ( // see [R5]
      (ce_i && reg_req_i.wr && reg_req_i.addr == ADDR_ALERT_SEL_FAULTS && !ee_load_i.load)
      |=> $stable(false_undervoltage_clamp_trim_o) && $stable(load_voltage_trim_o)
       && $stable(alert_mask_monitors_o))
      else $error("fault mask write touched another register");

   id_write_ignored_a: assert property ( // see [R9] [R10]
      (ce_i && reg_req_i.wr && !ee_load_i.load
       && (reg_req_i.addr == ADDR_MAKER_ID || reg_req_i.addr == ADDR_SILICON_REV))
      |=> $stable(false_undervoltage_clamp_trim_o) && $stable(load_voltage_trim_o)
       && $stable(alert_mask_faults_o) && $stable(alert_mask_monitors_o))
      else $error("identity write changed a register");

   freeze_on_ce_a: assert property ( // see [R11]
      !ce_i |=> $stable(false_undervoltage_clamp_trim_o) && $stable(load_voltage_trim_o)
       && $stable(alert_mask_faults_o) && $stable(alert_mask_monitors_o)
       && $stable(reg_rdata_o) && $stable(reg_rd_ack_o))
      else $error("state moved with clock enable low");

   regs_idle_stable_a: assert property ( // see [R11]
      (ce_i && !reg_req_i.wr && !ee_load_i.load)
      |=> $stable(false_undervoltage_clamp_trim_o) && $stable(load_voltage_trim_o)
       && $stable(alert_mask_faults_o) && $stable(alert_mask_monitors_o))
      else $error("register changed without write or load");

   ee_other_ignored_a: assert property ( // see [R6]
      (ce_i && ee_load_i.load && !reg_req_i.wr
       && (ee_load_i.addr < EE_FALSE_UNDERVOLTAGE_CLAMP_TRIM || ee_load_i.addr > EE_ALERT_SEL_MONITORS))
      |=> $stable(false_undervoltage_clamp_trim_o) && $stable(load_voltage_trim_o)
       && $stable(alert_mask_faults_o) && $stable(alert_mask_monitors_o))
      else $error("unmapped preload changed a register");

   uv_read_back_a: assert property ( // see [R1]
      (ce_i && reg_req_i.rd && reg_req_i.addr == ADDR_FALSE_UNDERVOLTAGE_CLAMP_TRIM)
      |=> reg_rdata_o == $past(false_undervoltage_clamp_trim_o))
      else $error("clamp trim read wrong");

   lv_read_back_a: assert property ( // see [R3]
      (ce_i && reg_req_i.rd && reg_req_i.addr == ADDR_LOAD_VOLT_TRIM)
      |=> reg_rdata_o == $past(load_voltage_trim_o))
      else $error("load trim read wrong");

   fmask_read_back_a: assert property ( // see [R5]
      (ce_i && reg_req_i.rd && reg_req_i.addr == ADDR_ALERT_SEL_FAULTS)
      |=> reg_rdata_o == $past(alert_mask_faults_o))
      else $error("fault mask read wrong");

   mmask_read_back_a: assert property ( // see [R8]
      (ce_i && reg_req_i.rd && reg_req_i.addr == ADDR_ALERT_SEL_MONITORS)
      |=> reg_rdata_o == $past(alert_mask_monitors_o))
      else $error("monitor mask read wrong");

   unmapped_read_a: assert property ( // see [R11]
      (ce_i && reg_req_i.rd
       && (reg_req_i.addr < ADDR_FALSE_UNDERVOLTAGE_CLAMP_TRIM || reg_req_i.addr > ADDR_SILICON_REV))
      |=> reg_rd_ack_o && reg_rdata_o == READ_UNMAPPED)
      else $error("unmapped read not answered with zero");

   rdata_hold_a: assert property ( // see [R11]
      !(ce_i && reg_req_i.rd)
      |=> $stable(reg_rdata_o))
      else $error("read data moved without a read");

   ack_needs_read_a: assert property ( // see [R11]
      reg_rd_ack_o
      |-> $past(reg_req_i.rd) || !$past(ce_i))
      else $error("read answer without a read");

   write_no_ack_a: assert property ( // see [R11]
      (ce_i && reg_req_i.wr && !reg_req_i.rd)
      |=> !reg_rd_ack_o)
      else $error("write raised the read answer");

   monitor_or_a: assert property ( // see [R7]
      (|(mon_sense & alert_mask_monitors_o))
      |-> fault_alert_output_o)
      else $error("enabled monitor did not raise alert");

   micro_level_a: assert property ( // see [R8]
      alert_mask_monitors_o[MB_MICRO]
      |-> fault_alert_output_o)
      else $error("micro request bit not on alert");

   masks_clear_a: assert property ( // see [R12]
      (alert_mask_faults_o == 8'h00 && alert_mask_monitors_o == 8'h00)
      |-> !fault_alert_output_o)
      else $error("alert with both masks clear");

   fault_sync_depth_a: assert property ( // see [R5]
      ($past(ce_i) && $past(ce_i, 2) && !$past(rst_i) && !$past(rst_i, 2))
      |-> fault_sense == ($past(fault_flags_i, 2) ^ FAULT_INVERT))
      else $error("fault flag path not two stages");

   mon_sync_depth_a: assert property ( // see [R7]
      ($past(ce_i) && $past(ce_i, 2) && !$past(rst_i) && !$past(rst_i, 2))
      |-> mon_sense == (($past(mon_raw, 2) ^ MON_INVERT) & MON_GATE))
      else $error("monitor flag path not two stages");

   reset_clears_a: assert property ( // see [R2]
      $past(rst_i)
      |-> false_undervoltage_clamp_trim_o == REG_RESET && load_voltage_trim_o == REG_RESET
       && alert_mask_faults_o == REG_RESET && alert_mask_monitors_o == REG_RESET
       && reg_rdata_o == REG_RESET && !reg_rd_ack_o && !fault_alert_output_o)
      else $error("state not cleared by reset");

   micro_alert_c: cover property (
      $rose(alert_mask_monitors_o[MB_MICRO]) ##1 fault_alert_output_o);
   fault_alert_c: cover property (
      !fault_alert_output_o ##1 fault_alert_output_o ##[1:8] !fault_alert_output_o);
   ee_preload_c: cover property (ee_load_i.load ##2 ee_load_i.load ##2 ee_load_i.load);
   id_read_c: cover property (reg_req_i.rd && reg_req_i.addr == ADDR_MAKER_ID);
   ce_freeze_c: cover property (!ce_i ##1 !ce_i);
endmodule // trim_alert_select_registers

// File: design/trim_alert_pkg.sv
// Constants, field layouts and carrier types for the trim and alert-select register bank.
// Assumes an SMBus engine hands over byte accesses and a power-up loader streams EEPROM bytes.
// Notes on behaviour
// [R1] Clamp trim code raises threshold 3.1 mV/step
// [R2] Power-up loads clamp trim from EEPROM 8118h
// [R3] Load voltage trim R/W, preloaded from 8119h
// [R4] Alert is OR of all enabled flags
// [R5] Fault mask bit order OV down to share
// [R6] Fault mask preloaded from EEPROM 811Ah
// [R7] Monitor mask from 811Bh, supply, monitors
// [R8] Monitor mask bit 2 forces alert directly
// [R9] Maker identification register is read-only
// [R10] Revision: generation high nibble, minor low
// [R11] Registers reached through serial management bus
// [R12] Alert releases when nothing enabled remains
package trim_alert_pkg;
   localparam logic [7:0] ADDR_FALSE_UNDERVOLTAGE_CLAMP_TRIM = 8'h18;
   localparam logic [7:0] ADDR_LOAD_VOLT_TRIM = 8'h19;
   localparam logic [7:0] ADDR_ALERT_SEL_FAULTS = 8'h1A;
   localparam logic [7:0] ADDR_ALERT_SEL_MONITORS = 8'h1B;
   localparam logic [7:0] ADDR_MAKER_ID = 8'h1C;
   localparam logic [7:0] ADDR_SILICON_REV = 8'h1D;

   localparam logic [15:0] EE_FALSE_UNDERVOLTAGE_CLAMP_TRIM = 16'h8118;
   localparam logic [15:0] EE_LOAD_VOLT_TRIM = 16'h8119;
   localparam logic [15:0] EE_ALERT_SEL_FAULTS = 16'h811A;
   localparam logic [15:0] EE_ALERT_SEL_MONITORS = 16'h811B;

   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;

   // Clamp trim scale, in microvolts and millivolts
   localparam int UV_CLAMP_STEP_UV = 3100;
   localparam int UV_CLAMP_MIN_MV = 1300;
   localparam int UV_CLAMP_MAX_MV = 2100;

   // Fault mask bit positions
   localparam int FB_OV = 7;
   localparam int FB_UV = 6;
   localparam int FB_OCP_TIMEOUT = 5;
   localparam int FB_AC_SENSE = 4;
   localparam int FB_OCP_FLAG = 3;
   localparam int FB_OVER_TEMP = 2;
   localparam int FB_ORFET = 1;
   localparam int FB_SHARE = 0;
   // Monitor mask bit positions
   localparam int MB_SUPPLY = 7;
   localparam int MB_MON1 = 6;
   localparam int MB_MON2 = 5;
   localparam int MB_MON3 = 4;
   localparam int MB_MON4 = 3;
   localparam int MB_MICRO = 2;
   localparam int MB_SUPERVISOR_INPUT_FIVE_FLAG = 1;

   // Good-level inputs whose fault sense is the inverse
   localparam logic [7:0] FAULT_INVERT = 8'h13;
   localparam logic [7:0] MON_INVERT = 8'h80;
   // Bits of the monitor mask that gate a flag
   localparam logic [7:0] MON_GATE = 8'hFA;

   typedef struct packed {
      logic ov_fault;
      logic uv_fault;
      logic ocp_timeout;
      logic ac_sense_good;
      logic ocp_flag;
      logic over_temp;
      logic orfet_good;
      logic current_share_good;
   } fault_flags_type;

   typedef struct packed {
      logic supply_good;
      logic mon1_flag;
      logic mon2_flag;
      logic mon3_flag;
      logic mon4_flag;
      logic supervisor_input_five_flag;
   } monitor_flags_type;

   typedef struct packed {
      logic load;
      logic [15:0] addr;
      logic [7:0] data;
   } ee_load_type;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_type;
endpackage

// File: sim/host_model.sv
// Host-side model: SMBus engine strobes and power-up EEPROM loader.
// Assumes the bank samples requests on the rising edge of clock_i.
`timescale 1ns/10ps
module host_model
   import trim_alert_pkg::*;
(
   input wire logic clock_i,
   output reg_req_type reg_req_o,
   output ee_load_type ee_load_o
);
   initial begin
      reg_req_o = '0;
      ee_load_o = '0;
   end
   // Released fields flip, so a stale value is never mistaken for live data
   task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] data);
      @(posedge clock_i);
      reg_req_o <= '{wr: wr, rd: ~wr, addr: addr, wdata: data};
      @(posedge clock_i);
      reg_req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~data};
   endtask
   task automatic load(input logic [15:0] addr, input logic [7:0] data);
      @(posedge clock_i);
      ee_load_o <= '{load: 1'b1, addr: addr, data: data};
      @(posedge clock_i);
      ee_load_o <= '{load: 1'b0, addr: ~addr, data: ~data};
   endtask
endmodule // host_model

// File: sim/trim_alert_select_registers_tb.sv
// Self-checking bench for the trim and alert-select register bank.
// Assumes host_model drives the register and loader strobes; flags come from here.
`timescale 1ns/10ps
module trim_alert_select_registers_tb;
   import trim_alert_pkg::*;
   // Arbitrary identity values
   localparam logic [7:0] MAKER = 8'hC3;
   localparam logic [7:0] REV = 8'h1E;
   logic clock_i = 1'b0;
   logic rst_i = 1'b1;
   logic ce_i = 1'b1;
   reg_req_type reg_req;
   ee_load_type ee_load;
   fault_flags_type fault_flags = 8'h13;
   monitor_flags_type monitor_flags = 6'h20;
   logic [7:0] rdata, uv_trim, load_trim, mask_f, mask_m;
   logic rd_ack, alert;
   logic [7:0] expect_q[$];
   logic [7:0] shadow[4];
   int mismatches = 0;
   int checked = 0;
   initial forever #20 clock_i = ~clock_i;
   host_model host(.clock_i(clock_i), .reg_req_o(reg_req), .ee_load_o(ee_load));
   trim_alert_select_registers #(.MAKER_ID(MAKER), .REV_MAJOR(REV[7:4]), .REV_MINOR(REV[3:0]))
      dut(.clock_i(clock_i), .rst_i(rst_i), .ce_i(ce_i), .reg_req_i(reg_req),
      .reg_rdata_o(rdata), .reg_rd_ack_o(rd_ack), .ee_load_i(ee_load),
      .fault_flags_i(fault_flags), .monitor_flags_i(monitor_flags),
      .false_undervoltage_clamp_trim_o(uv_trim), .load_voltage_trim_o(load_trim),
      .alert_mask_faults_o(mask_f), .alert_mask_monitors_o(mask_m),
      .fault_alert_output_o(alert));
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
      expect_q.push_back(exp);
      host.access(1'b0, addr, 8'h00);
   endtask
   task automatic wr(input logic [7:0] addr, input logic [7:0] data);
      host.access(1'b1, addr, data);
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask
   task automatic report_and_stop;
      $display("Comparisons %0d, mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // Read answers are matched in issue order
   always @(posedge clock_i) begin
      if (rd_ack === 1'b1) begin
         if (expect_q.size() == 0) check("unexpected ack", 8'h00, 8'hFF);
         else check("read data", expect_q.pop_front(), rdata);
      end
   end
   initial begin
      repeat (100000) @(posedge clock_i);
      check("watchdog", 8'h00, 8'hFF);
      report_and_stop();
   end
   initial begin
      int i;
      logic [7:0] v;
      void'($urandom(69));
      repeat (12) @(posedge clock_i);
      rst_i <= 1'b0;
      for (i = 0; i < 4; i++) rd(8'(ADDR_FALSE_UNDERVOLTAGE_CLAMP_TRIM + i), REG_RESET);
      rd(ADDR_MAKER_ID, MAKER);
      rd(ADDR_SILICON_REV, REV);
      rd(8'h3C, READ_UNMAPPED);
      $display("Test reset values done");
      for (i = 0; i < 4; i++) begin
         shadow[i] = 8'($urandom);
         host.load(16'(EE_FALSE_UNDERVOLTAGE_CLAMP_TRIM + i), shadow[i]);
      end
      host.load(16'h811C, 8'hFF);
      settle(1);
      check("clamp trim", shadow[0], uv_trim);
      check("load trim", shadow[1], load_trim);
      check("fault mask", shadow[2], mask_f);
      check("monitor mask", shadow[3], mask_m);
      $display("Test power-up load done");
      for (i = 0; i < 4; i++) begin
         shadow[i] = 8'($urandom);
         wr(8'(ADDR_FALSE_UNDERVOLTAGE_CLAMP_TRIM + i), shadow[i]);
      end
      wr(ADDR_MAKER_ID, 8'h00);
      wr(ADDR_SILICON_REV, 8'h00);
      for (i = 0; i < 4; i++) rd(8'(ADDR_FALSE_UNDERVOLTAGE_CLAMP_TRIM + i), shadow[i]);
      rd(ADDR_MAKER_ID, MAKER);
      rd(ADDR_SILICON_REV, REV);
      @(posedge clock_i) ce_i <= 1'b0;
      wr(ADDR_FALSE_UNDERVOLTAGE_CLAMP_TRIM, ~shadow[0]);
      @(posedge clock_i) ce_i <= 1'b1;
      rd(ADDR_FALSE_UNDERVOLTAGE_CLAMP_TRIM, shadow[0]);
      $display("Test host access done");
      wr(ADDR_ALERT_SEL_MONITORS, 8'h00);
      for (i = 0; i < 8; i++) begin
         wr(ADDR_ALERT_SEL_FAULTS, ~(8'h01 << i));
         @(posedge clock_i) fault_flags <= 8'h13 ^ (8'h01 << i);
         settle(3);
         check("alert masked fault", 8'h00, {7'h00, alert});
         wr(ADDR_ALERT_SEL_FAULTS, 8'h01 << i);
         settle(1);
         check("alert fault", 8'h01, {7'h00, alert});
         @(posedge clock_i) fault_flags <= 8'h13;
         settle(3);
         check("alert fault gone", 8'h00, {7'h00, alert});
      end
      $display("Test fault masks done");
      wr(ADDR_ALERT_SEL_FAULTS, 8'h00);
      for (i = 0; i < 6; i++) begin
         v = (i == 0) ? 8'h02 : 8'(8'h04 << i);
         wr(ADDR_ALERT_SEL_MONITORS, ~v & ~8'h04);
         @(posedge clock_i) monitor_flags <= 6'h20 ^ (6'h01 << i);
         settle(3);
         check("alert masked monitor", 8'h00, {7'h00, alert});
         wr(ADDR_ALERT_SEL_MONITORS, v);
         settle(1);
         check("alert monitor", 8'h01, {7'h00, alert});
         @(posedge clock_i) monitor_flags <= 6'h20;
         settle(3);
         check("alert monitor gone", 8'h00, {7'h00, alert});
      end
      wr(ADDR_ALERT_SEL_MONITORS, 8'h04);
      settle(1);
      check("alert forced", 8'h01, {7'h00, alert});
      wr(ADDR_ALERT_SEL_MONITORS, 8'h00);
      settle(1);
      check("alert unforced", 8'h00, {7'h00, alert});
      $display("Test monitor masks done");
      for (i = 0; i < 20 && expect_q.size() > 0; i++) @(posedge clock_i);
      check("pending reads", 8'h00, 8'(expect_q.size()));
      report_and_stop();
   end
endmodule // trim_alert_select_registers_tb
